// [rsse_defs.svh]
// Offsets, field positions, reset values and opcodes of the execute block
`ifndef RSSE_DEFS_SVH
`define RSSE_DEFS_SVH
`define RSSE_ADDR_W         4
`define RSSE_OFS_WORK       4'h0
`define RSSE_OFS_STATUS     4'h4
`define RSSE_OFS_WATCHDOG   4'h8
`define RSSE_OFS_CONTROL    4'hC
`define RSSE_ST_C           0
`define RSSE_ST_DC          1
`define RSSE_ST_Z           2
`define RSSE_ST_PD          3
`define RSSE_ST_TO          4
`define RSSE_CTRL_WAKE      0
`define RSSE_STATUS_RST     5'h18
`define RSSE_WORK_RST       8'h00
`define RSSE_WDT_CLR        8'h00
`define RSSE_PRE_CLR        8'h00
`define RSSE_OPC_ROTATE     6'h0C
`define RSSE_OPC_SUBTRACT   6'h02
`define RSSE_OPC_SLEEP      12'h003
`endif

// [rsse_pkg.sv]
// Types shared by the execute block
package rsse_pkg;
  typedef struct packed {
    logic timeout_status_bit;
    logic powerdown_status_bit;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } rsse_status_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } rsse_file_wr_t;

  typedef enum logic [0:0] {
    RSSE_RUN   = 1'b0,
    RSSE_SLEEP = 1'b1
  } rsse_state_t;
endpackage : rsse_pkg

// [rsse_exec.sv]
// Execute logic for rotate right through carry, sleep and subtract work from file
//
// What this block does
// - Rotate right shifts operand one place; old carry to bit 7, bit 0 to carry.
// - Rotate decoded from 0011 00df ffff; d picks destination, low five bits file.
// - Rotate result goes to working register when d is 0, file when 1.
// - Subtract 0000 10df ffff computes file minus work, updates carry, digit carry, zero.
// - After sleep the oscillator halts and the block stays asleep until a bus write sets bit 0 of the control register.
// - Two's complement subtraction, work as subtrahend, d selects work or file.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "rsse_defs.svh"

module rsse_exec (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_in,
  input  wire logic                   instr_valid_in,
  input  wire logic [11:0]            instr_in,
  input  wire logic [7:0]             file_data_in,
  output rsse_pkg::rsse_file_wr_t     file_wr_out,
  output rsse_pkg::rsse_status_t      status_out,
  output logic                        sleep_out,
  input  wire logic [`RSSE_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out
);
  rsse_pkg::rsse_state_t   state_q;
  rsse_pkg::rsse_state_t   state_d;
  rsse_pkg::rsse_status_t  status_q;
  rsse_pkg::rsse_status_t  status_d;
  rsse_pkg::rsse_file_wr_t file_wr_d;
  logic [7:0]              work_q;
  logic [7:0]              work_d;
  logic [7:0]              wdt_cnt_q;
  logic [7:0]              wdt_pre_q;
  logic                    wait_q;
  logic [31:0]             rdata_q;

  // Bus access completes on the second edge; one wait cycle keeps readdata registered
  wire bus_req    = avs_read_in | avs_write_in;
  wire bus_done   = bus_req & ~wait_q;
  wire bus_wr     = avs_write_in & ~wait_q;
  wire wr_work    = bus_wr & (avs_address_in == `RSSE_OFS_WORK);
  wire wr_status  = bus_wr & (avs_address_in == `RSSE_OFS_STATUS);
  wire wr_wake    = bus_wr & (avs_address_in == `RSSE_OFS_CONTROL) & avs_writedata_in[`RSSE_CTRL_WAKE];

  wire [31:0] rd_mux =
    (avs_address_in == `RSSE_OFS_WORK)     ? {24'h000000, work_q} :
    (avs_address_in == `RSSE_OFS_STATUS)   ? {27'h0000000, status_q} :
    (avs_address_in == `RSSE_OFS_WATCHDOG) ? {16'h0000, wdt_pre_q, wdt_cnt_q} :
    (avs_address_in == `RSSE_OFS_CONTROL)  ? {31'h00000000, state_q == rsse_pkg::RSSE_SLEEP} :
    32'h00000000;

  // Instructions offered while asleep are ignored: the fetch clock is stopped
  wire running  = (state_q == rsse_pkg::RSSE_RUN);
  wire take     = instr_valid_in & running;
  wire is_rot   = take & (instr_in[11:6] == `RSSE_OPC_ROTATE);
  wire is_sub   = take & (instr_in[11:6] == `RSSE_OPC_SUBTRACT);
  wire is_slp   = take & (instr_in == `RSSE_OPC_SLEEP);
  wire dest_f   = instr_in[5];

  wire [7:0] rot_res  = {status_q.carry_flag, file_data_in[7:1]};
  wire [8:0] sub_full = {1'b0, file_data_in} + {1'b0, ~work_q} + 9'h001;
  wire [4:0] sub_nib  = {1'b0, file_data_in[3:0]} + {1'b0, ~work_q[3:0]} + 5'h01;
  wire [7:0] sub_res  = sub_full[7:0];
  wire [7:0] result   = is_rot ? rot_res : sub_res;
  wire       exec     = is_rot | is_sub;

  always_comb
  begin
    work_d = work_q;
    if (wr_work)
      work_d = avs_writedata_in[7:0];
    if (exec & ~dest_f)
      work_d = result;
  end

  always_comb
  begin
    file_wr_d.we   = exec & dest_f;
    file_wr_d.addr = instr_in[4:0];
    file_wr_d.data = result;
  end

  // Software may write only the arithmetic flags; the instruction wins a same-cycle clash
  always_comb
  begin
    status_d = status_q;
    if (wr_status)
    begin
      status_d.carry_flag       = avs_writedata_in[`RSSE_ST_C];
      status_d.digit_carry_flag = avs_writedata_in[`RSSE_ST_DC];
      status_d.zero_flag        = avs_writedata_in[`RSSE_ST_Z];
    end
    if (is_rot)
      status_d.carry_flag = file_data_in[0];
    if (is_sub)
    begin
      status_d.carry_flag       = sub_full[8];
      status_d.digit_carry_flag = sub_nib[4];
      status_d.zero_flag        = (sub_res == 8'h00);
    end
    if (is_slp)
    begin
      status_d.timeout_status_bit   = 1'b1;
      status_d.powerdown_status_bit = 1'b0;
    end
  end

  always_comb
  begin
    state_d = state_q;
    if (is_slp)
      state_d = rsse_pkg::RSSE_SLEEP;
    else if (wr_wake)
      state_d = rsse_pkg::RSSE_RUN;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_q     <= rsse_pkg::RSSE_RUN;
      status_q    <= `RSSE_STATUS_RST;
      work_q      <= `RSSE_WORK_RST;
      file_wr_out <= '0;
    end
    else
    begin
      state_q     <= state_d;
      status_q    <= status_d;
      work_q      <= work_d;
      file_wr_out <= file_wr_d;
    end
  end

  // Watchdog keeps counting in sleep, as it has its own oscillator
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in | is_slp)
    begin
      wdt_pre_q <= `RSSE_PRE_CLR;
      wdt_cnt_q <= `RSSE_WDT_CLR;
    end
    else
    begin
      wdt_pre_q <= wdt_pre_q + 8'h01;
      wdt_cnt_q <= wdt_cnt_q + {7'h00, wdt_pre_q == 8'hFF};
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q  <= ~(bus_req & wait_q);
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign status_out          = status_q;
  assign sleep_out           = (state_q == rsse_pkg::RSSE_SLEEP);

  a_rot_work_value: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (is_rot & ~dest_f) |=> (work_q == {$past(status_q.carry_flag), $past(file_data_in[7:1])}) && !file_wr_out.we)
    else $error("rotate result in work register wrong");
  a_rot_carry_out: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    is_rot |=> status_q.carry_flag == $past(file_data_in[0]))
    else $error("rotate carry wrong");
  a_file_wr_decode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    file_wr_out.we |-> $past(instr_in[5]) && file_wr_out.addr == $past(instr_in[4:0])
      && ($past(instr_in[11:6]) == 6'h0C || $past(instr_in[11:6]) == 6'h02))
    else $error("file write without matching instruction");
  a_rot_file_dest: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (is_rot & dest_f & ~wr_work) |=> file_wr_out.we && file_wr_out.data == {$past(status_q.carry_flag),
      $past(file_data_in[7:1])} && work_q == $past(work_q))
    else $error("rotate to file wrong");
  a_sleep_clears: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    is_slp |=> wdt_cnt_q == 8'h00 && wdt_pre_q == 8'h00 && status_q.timeout_status_bit
      && !status_q.powerdown_status_bit)
    else $error("sleep did not clear watchdog or set status");
  a_sub_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (is_sub & dest_f) |=> file_wr_out.we && file_wr_out.data == 8'($past(file_data_in) - $past(work_q))
      && status_q.carry_flag == ($past(file_data_in) >= $past(work_q)))
    else $error("subtract result or carry wrong");
  a_sub_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    is_sub |=> status_q.zero_flag == ($past(file_data_in) == $past(work_q))
      && status_q.digit_carry_flag == ($past(file_data_in[3:0]) >= $past(work_q[3:0])))
    else $error("subtract zero or digit carry wrong");
  a_sleep_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (is_slp ##1 !wr_wake) |=> sleep_out && !file_wr_out.we)
    else $error("sleep not held or instruction executed");
  a_rot_flags_kept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (is_rot & ~wr_status) |=> status_q[4:1] == $past(status_q[4:1]))
    else $error("rotate changed a flag other than carry");
  a_bus_one_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (bus_req & wait_q) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing wrong");
  a_sub_work_dest: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (is_sub & ~dest_f) |=> work_q == 8'($past(file_data_in) - $past(work_q)) && !file_wr_out.we)
    else $error("subtract result in work register wrong");
  a_asleep_ignored: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (instr_valid_in & ~running & ~bus_wr) |=> !file_wr_out.we && work_q == $past(work_q)
      && status_q == $past(status_q))
    else $error("instruction executed while asleep");
  a_wake_resumes: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr_wake & ~is_slp) |=> !sleep_out)
    else $error("wake write did not resume");
  a_bus_work_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr_work & ~(exec & ~dest_f)) |=> work_q == $past(avs_writedata_in[7:0]))
    else $error("work register write lost");
  a_bus_status_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr_status & ~is_rot & ~is_sub) |=> status_q[2:0] == $past(avs_writedata_in[2:0]))
    else $error("status flag write lost");
endmodule : rsse_exec

// [rsse_file_model.sv]
// File register model that feeds operands to the execute block
`timescale 1ns/1ps
module rsse_file_model (
  input  wire logic              clk_sys_in,
  input  wire logic [4:0]        addr_in,
  input  rsse_pkg::rsse_file_wr_t wr_in,
  output logic [7:0]             data_out
);
  logic [7:0] mem_q [32];
  // Forward a write in flight so back-to-back instructions see the new value
  assign data_out = (wr_in.we && wr_in.addr == addr_in) ? wr_in.data : mem_q[addr_in];
  initial for (int i = 0; i < 32; i++) mem_q[i] = 8'h5A ^ 8'(i * 7);
  always @(posedge clk_sys_in) if (wr_in.we) mem_q[wr_in.addr] <= wr_in.data;
endmodule : rsse_file_model

// [tb_top.sv]
// Self-checking bench for the execute block against a reference model
`timescale 1ns/1ps
module tb_top;
  logic                    clk_sys_in = 1'b0, rst_in = 1'b1, instr_valid_in = 1'b0;
  logic                    avs_read_in = 1'b0, avs_write_in = 1'b0, sleep_out, avs_waitrequest_out;
  logic [11:0]             instr_in = 12'h000, ins;
  logic [3:0]              avs_address_in = 4'h0;
  logic [31:0]             avs_writedata_in = 32'h0, avs_readdata_out, rd, r, seed = 32'hAF444CA5;
  logic [7:0]              file_data_in, w, res, mf [32];
  rsse_pkg::rsse_file_wr_t file_wr_out, ewr;
  rsse_pkg::rsse_status_t  status_out, est;
  int                      err_count = 0, checked = 0, cyc = 0;
  rsse_exec rsse_exec_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .file_data_in(file_data_in), .file_wr_out(file_wr_out), .status_out(status_out),
    .sleep_out(sleep_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out));
  rsse_file_model rsse_file_model_i (.clk_sys_in(clk_sys_in), .addr_in(instr_in[4:0]),
    .wr_in(file_wr_out), .data_out(file_data_in));
  always #50 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // Request held until the edge that sees waitrequest low; data taken as that edge sees it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic step(input logic [11:0] i);
    logic [7:0] f;
    f = mf[i[4:0]];
    ewr = '0;
    if (i[11:6] == 6'h0C)
    begin
      res = {est.carry_flag, f[7:1]};
      est.carry_flag = f[0];
    end
    else if (i[11:6] == 6'h02)
    begin
      res = f - w;
      est.carry_flag = f >= w;
      est.digit_carry_flag = f[3:0] >= w[3:0];
      est.zero_flag = res == 8'h00;
    end
    if ((i[11:6] == 6'h0C || i[11:6] == 6'h02) && i[5]) ewr = '{1'b1, i[4:0], res};
    if (ewr.we) mf[i[4:0]] = res;
    else if (i[11:6] == 6'h0C || i[11:6] == 6'h02) w = res;
  endtask : step
  task automatic chk_exec();
    cmp("status", 32'(est), 32'(status_out));
    cmp("we", 32'(ewr.we), 32'(file_wr_out.we));
    if (ewr.we) cmp("file_wr", 32'(ewr), 32'(file_wr_out));
  endtask : chk_exec
  task automatic end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    for (int i = 0; i < 32; i++) mf[i] = 8'h5A ^ 8'(i * 7);
    ewr = '0;
    est = 5'h18;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    cmp("status_rst", 32'h18, rd);
    r = xs();
    bus(1'b1, 4'h0, r);
    w = r[7:0];
    bus(1'b1, 4'h4, r);
    est[2:0] = r[2:0];
    bus(1'b0, 4'h0, 32'h0);
    cmp("work", 32'(w), rd);
    repeat (400)
    begin
      @(posedge clk_sys_in);
      r = xs();
      ins = {r[1] ? 6'h02 : 6'h0C, r[7:2]};
      if (r[9:8] == 2'b11) ins = {r[10] ? 6'h0D : 6'h03, r[16:11]};
      instr_valid_in <= !(r[12:11] == 2'b00);
      instr_in <= ins;
      #1 chk_exec();
      if (r[12:11] != 2'b00) step(ins);
      else ewr = '0;
    end
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b1;
    instr_in <= 12'h003;
    #1 chk_exec();
    @(posedge clk_sys_in);
    instr_in <= 12'h325;
    est.timeout_status_bit = 1'b1;
    est.powerdown_status_bit = 1'b0;
    ewr = '0;
    #1 chk_exec();
    cmp("sleep", 32'h1, 32'(sleep_out));
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
    #1 chk_exec();
    bus(1'b0, 4'h8, 32'h0);
    cmp("watchdog", 32'h0, 32'(rd[7:0]));
    cmp("prescaler", 32'h2, 32'(rd[15:8]));
    bus(1'b1, 4'hC, 32'h1);
    @(posedge clk_sys_in);
    #1 cmp("awake", 32'h0, 32'(sleep_out));
    bus(1'b0, 4'h0, 32'h0);
    cmp("work_end", 32'(w), rd);
    end_of_test();
  end
endmodule : tb_top
